// ---- logic/ltpc_pkg.sv ----
package ltpc_pkg;

  // ----------------------------------------
  // bus geometry
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int SAMPLE_W = 16;
  localparam int RESID_W = 3;
  localparam int CNT_W = 6;

  // ----------------------------------------
  // register indices, byte address = 4 * index
  // ----------------------------------------
  localparam logic [7:0] IDX_SRC_PERS = 8'hA6;
  localparam logic [7:0] IDX_STARTUP_RESID = 8'hA7;
  localparam logic [7:0] IDX_RSVD_CFG = 8'hA8;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hC0;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'hC1;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'hC2;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int SRC_LSB = 4;
  localparam int PERS_LSB = 0;
  localparam int STARTUP_BIT = 5;
  localparam int FLOOR_LSB = 2;
  localparam int CEIL_LSB = 0;
  localparam int EVT_LIGHT = 0;
  localparam int EVT_SAMPLE = 1;
  localparam int NUM_EVT = 2;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] RST_SRC_PERS = 8'h00;
  localparam logic [7:0] RST_STARTUP_RESID = 8'h03;
  localparam logic [7:0] RST_RSVD_CFG = 8'h01;
  localparam logic [1:0] RST_IRQ_ENABLE = 2'h0;

  // ----------------------------------------
  // persistence table
  // ----------------------------------------
  localparam logic [3:0] PERS_EVERY = 4'h0;
  localparam logic [3:0] PERS_SCALED_FROM = 4'h4;
  localparam logic [5:0] PERS_OFFSET = 6'h03;
  localparam logic [5:0] CNT_MAX = 6'h3F;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } ltpc_apb_req_type;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] prdata;
  } ltpc_apb_rsp_type;

  typedef struct packed {
    logic done;
    logic [SAMPLE_W-1:0] mod0;
    logic [SAMPLE_W-1:0] mod1;
  } ltpc_sample_type;

endpackage

// ---- logic/ltpc_top.sv ----
// Notes on behaviour
// - A two-bit source field picks modulator zero (00, reset) or modulator one (01) for threshold checks.
// - Consecutive out-of-range samples are counted and the light event fires once the count reaches the persistence target.
// - Any in-range sample returns the persistence counter to zero.
// - Persistence 0 fires on every measurement, 1 on any out-of-range sample, 2 and 3 after that many in a row.
// - Persistence 4 to 15 needs five times (value minus three) consecutive out-of-range samples.
// - The full-startup bit, clear at reset, requests the complete start procedure for every sample.
// - The residual bit count is held at or above the floor code unless the ceiling is lower (0 to 3 bits, 0 at reset meaning off).
// - The residual bit count is held at or below the ceiling code plus one (1 to 4 bits, 4 bits at reset).
`timescale 1ns/1ns
`default_nettype none

module ltpc_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // register bus
  input wire ltpc_pkg::ltpc_apb_req_type apb_i,
  output ltpc_pkg::ltpc_apb_rsp_type apb_o,
  // measurement side
  input wire ltpc_pkg::ltpc_sample_type sample_i,
  input wire logic [ltpc_pkg::SAMPLE_W-1:0] low_threshold_i,
  input wire logic [ltpc_pkg::SAMPLE_W-1:0] high_threshold_i,
  input wire logic [ltpc_pkg::RESID_W-1:0] residual_req_i,
  // control outputs
  output logic [1:0] compare_source_select_o,
  output logic full_startup_per_sample_o,
  output logic [ltpc_pkg::RESID_W-1:0] residual_bits_o,
  output logic light_event_o,
  output logic irq_o
);

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] src_pers_ff;
  logic [7:0] startup_resid_ff;
  logic [ltpc_pkg::NUM_EVT-1:0] status_ff;
  logic [ltpc_pkg::NUM_EVT-1:0] enable_ff;
  logic [ltpc_pkg::CNT_W-1:0] cnt_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [ltpc_pkg::DATA_W-1:0] prdata_ff;
  logic [1:0] src_ff;
  logic startup_ff;
  logic [ltpc_pkg::RESID_W-1:0] resid_ff;
  logic event_ff;
  logic irq_ff;

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire logic [7:0] idx = apb_i.paddr[9:2];
  wire logic addr_ok = (apb_i.paddr[1:0] == 2'h0) && (apb_i.paddr[11:10] == 2'h0);
  wire logic hit_sp = addr_ok && (idx == ltpc_pkg::IDX_SRC_PERS);
  wire logic hit_sr = addr_ok && (idx == ltpc_pkg::IDX_STARTUP_RESID);
  wire logic hit_rs = addr_ok && (idx == ltpc_pkg::IDX_RSVD_CFG);
  wire logic hit_st = addr_ok && (idx == ltpc_pkg::IDX_IRQ_STATUS);
  wire logic hit_cl = addr_ok && (idx == ltpc_pkg::IDX_IRQ_CLEAR);
  wire logic hit_en = addr_ok && (idx == ltpc_pkg::IDX_IRQ_ENABLE);
  wire logic mapped = hit_sp | hit_sr | hit_rs | hit_st | hit_cl | hit_en;
  wire logic access = apb_i.psel && apb_i.penable;
  wire logic first_access = access && !pready_ff;
  wire logic wr_now = access && pready_ff && apb_i.pwrite && mapped;
  logic [ltpc_pkg::DATA_W-1:0] rd_mux;

  always_comb begin
    if (hit_sp) begin
      rd_mux = {24'h000000, src_pers_ff};
    end else if (hit_sr) begin
      rd_mux = {24'h000000, startup_resid_ff};
    end else if (hit_rs) begin
      rd_mux = {24'h000000, ltpc_pkg::RST_RSVD_CFG};
    end else if (hit_st) begin
      rd_mux = {30'h0, status_ff};
    end else if (hit_en) begin
      rd_mux = {30'h0, enable_ff};
    end else begin
      rd_mux = 32'h00000000;
    end
  end

  // ----------------------------------------
  // apb slave, one wait state
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else begin
      pready_ff <= first_access;
      pslverr_ff <= first_access && !mapped;
      prdata_ff <= (first_access && !apb_i.pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // ----------------------------------------
  // configuration registers
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      src_pers_ff <= ltpc_pkg::RST_SRC_PERS;
      startup_resid_ff <= ltpc_pkg::RST_STARTUP_RESID;
      enable_ff <= ltpc_pkg::RST_IRQ_ENABLE;
    end else begin
      if (wr_now && hit_sp) begin
        src_pers_ff <= {2'h0, apb_i.pwdata[5:0]};
      end
      if (wr_now && hit_sr) begin
        startup_resid_ff <= {2'h0, apb_i.pwdata[5], 1'b0, apb_i.pwdata[3:0]};
      end
      if (wr_now && hit_en) begin
        enable_ff <= apb_i.pwdata[ltpc_pkg::NUM_EVT-1:0];
      end
    end
  end

  // ----------------------------------------
  // fields
  // ----------------------------------------
  wire logic [1:0] src_sel = src_pers_ff[ltpc_pkg::SRC_LSB +: 2];
  wire logic [3:0] pers = src_pers_ff[ltpc_pkg::PERS_LSB +: 4];
  wire logic startup_bit = startup_resid_ff[ltpc_pkg::STARTUP_BIT];
  wire logic [1:0] floor_code = startup_resid_ff[ltpc_pkg::FLOOR_LSB +: 2];
  wire logic [1:0] ceil_code = startup_resid_ff[ltpc_pkg::CEIL_LSB +: 2];

  // ----------------------------------------
  // threshold and persistence filter
  // ----------------------------------------
  wire logic [ltpc_pkg::SAMPLE_W-1:0] sample = (src_sel == 2'h1) ? sample_i.mod1 : sample_i.mod0;
  wire logic outside = (sample < low_threshold_i) || (sample > high_threshold_i);
  wire logic [5:0] pers_ext = {2'h0, pers};
  wire logic [5:0] pers_less = pers_ext - ltpc_pkg::PERS_OFFSET;
  wire logic [5:0] target = (pers < ltpc_pkg::PERS_SCALED_FROM) ? pers_ext : ((pers_less << 2) + pers_less);
  wire logic [5:0] cnt_inc = (cnt_ff == ltpc_pkg::CNT_MAX) ? cnt_ff : (cnt_ff + 6'h01);
  wire logic every = (pers == ltpc_pkg::PERS_EVERY);
  wire logic reached = outside && (cnt_inc >= target);
  wire logic fire = sample_i.done && (every || reached);
  logic [5:0] nxt_cnt;

  always_comb begin
    if (!sample_i.done) begin
      nxt_cnt = cnt_ff;
    end else if (!outside || fire) begin
      nxt_cnt = 6'h00;
    end else begin
      nxt_cnt = cnt_inc;
    end
  end

  // ----------------------------------------
  // residual clamp
  // ----------------------------------------
  wire logic [2:0] floor_bits = {1'b0, floor_code};
  wire logic [2:0] ceil_bits = {1'b0, ceil_code} + 3'h1;
  wire logic [2:0] above_floor = (residual_req_i < floor_bits) ? floor_bits : residual_req_i;
  wire logic [2:0] nxt_resid = (above_floor > ceil_bits) ? ceil_bits : above_floor;

  // ----------------------------------------
  // interrupt status, set wins over clear
  // ----------------------------------------
  wire logic [1:0] evt_set = {sample_i.done, fire};
  wire logic [1:0] evt_clr = (wr_now && hit_cl) ? apb_i.pwdata[1:0] : 2'h0;
  wire logic [1:0] nxt_status = (status_ff & ~evt_clr) | evt_set;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_ff <= 6'h00;
      status_ff <= 2'h0;
      irq_ff <= 1'b0;
      event_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      status_ff <= nxt_status;
      irq_ff <= |(nxt_status & enable_ff);
      event_ff <= fire;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      src_ff <= 2'h0;
      startup_ff <= 1'b0;
      resid_ff <= 3'h0;
    end else begin
      src_ff <= src_sel;
      startup_ff <= startup_bit;
      resid_ff <= nxt_resid;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign apb_o.pready = pready_ff;
  assign apb_o.pslverr = pslverr_ff;
  assign apb_o.prdata = prdata_ff;
  assign compare_source_select_o = src_ff;
  assign full_startup_per_sample_o = startup_ff;
  assign residual_bits_o = resid_ff;
  assign light_event_o = event_ff;
  assign irq_o = irq_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  src_follow_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ##1 compare_source_select_o == $past(src_sel)) else $error("source select not mirrored");

  every_cycle_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    sample_i.done && pers == 4'h0 |=> light_event_o) else $error("persistence zero did not fire");

  inrange_clear_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    sample_i.done && !outside && pers != 4'h0 |=> cnt_ff == 6'h00 && !light_event_o) else $error("in-range kept count");

  fire_cause_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    light_event_o |-> $past(sample_i.done) && ($past(pers) == 4'h0 || ($past(outside) && $past(cnt_ff) + 6'h01 >= $past(target))))
    else $error("event without cause");

  scaled_target_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    pers >= 4'h4 |-> target == 6'(5 * (int'(pers) - 3))) else $error("scaled persistence target wrong");

  startup_follow_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ##1 full_startup_per_sample_o == $past(startup_bit)) else $error("startup bit not mirrored");

  resid_floor_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    floor_bits <= ceil_bits |=> residual_bits_o >= $past(floor_bits)) else $error("residual under floor");

  resid_ceil_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ##1 residual_bits_o <= $past(ceil_bits)) else $error("residual over ceiling");

  strict_range_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    sample_i.done && sample == low_threshold_i && sample <= high_threshold_i |=> cnt_ff == 6'h00)
    else $error("edge sample counted as outside");

  irq_level_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ##1 irq_o == |($past(nxt_status) & $past(enable_ff))) else $error("irq level mismatch");

endmodule

`default_nettype wire

// ---- verification/light_threshold_persistence_cfg_tb.sv ----
`timescale 1ns/1ns
`default_nettype none

module light_threshold_persistence_cfg_tb;
  // ----------------------------------------
  // stimulus and observed signals
  // ----------------------------------------
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  ltpc_pkg::ltpc_apb_req_type apb_req = '0;
  ltpc_pkg::ltpc_apb_rsp_type apb_o;
  ltpc_pkg::ltpc_sample_type smp = '0;
  logic [15:0] low_threshold_i = 16'h0064;
  logic [15:0] high_threshold_i = 16'h00C8;
  logic [2:0] residual_req_i = 3'h0;
  logic [1:0] compare_source_select_o;
  logic full_startup_per_sample_o;
  logic [2:0] residual_bits_o;
  logic light_event_o;
  logic irq_o;
  int err_count = 0;
  int checks_done = 0;
  logic [31:0] rdat;
  logic rerr;

  always #4 clk_i = ~clk_i;

  ltpc_top ltpc_top_i (.clk_i(clk_i), .reset_n_i(reset_n_i), .apb_i(apb_req), .apb_o(apb_o), .sample_i(smp),
    .low_threshold_i(low_threshold_i), .high_threshold_i(high_threshold_i), .residual_req_i(residual_req_i),
    .compare_source_select_o(compare_source_select_o), .full_startup_per_sample_o(full_startup_per_sample_o),
    .residual_bits_o(residual_bits_o), .light_event_o(light_event_o), .irq_o(irq_o));

  // ----------------------------------------
  // compare, verdict and access tasks
  // ----------------------------------------
  task automatic print_verdict();
    if (err_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [11:0] ad(input logic [7:0] idx);
    return {2'h0, idx, 2'h0};
  endfunction

  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
    int n;
    @(posedge clk_i);
    apb_req.psel <= 1'b1;
    apb_req.pwrite <= wr;
    apb_req.paddr <= addr;
    apb_req.pwdata <= wd;
    @(posedge clk_i);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (apb_o.pready !== 1'b1 && n < 20);
    if (apb_o.pready !== 1'b1) begin
      err_count++;
      print_verdict();
    end
    rdat = apb_o.prdata;
    rerr = apb_o.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    apb(1'b1, ad(idx), d);
    check_val({31'h0, rerr}, 32'h0);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, ad(idx), 32'h0);
    check_val({rerr, rdat[30:0]}, exp);
  endtask

  // one done pulse, event checked in the following cycle
  task automatic send(input logic [15:0] m0, input logic [15:0] m1, input logic exp);
    @(posedge clk_i);
    smp <= '{done: 1'b1, mod0: m0, mod1: m1};
    @(posedge clk_i);
    smp.done <= 1'b0;
    #1;
    check_val({31'h0, light_event_o}, {31'h0, exp});
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    int tgt;
    repeat (16) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd_chk(ltpc_pkg::IDX_SRC_PERS, 32'h00);
    rd_chk(ltpc_pkg::IDX_STARTUP_RESID, 32'h03);
    rd_chk(ltpc_pkg::IDX_RSVD_CFG, 32'h01);
    rd_chk(ltpc_pkg::IDX_IRQ_ENABLE, 32'h00);
    check_val({30'h0, compare_source_select_o}, 32'h0);
    check_val({31'h0, full_startup_per_sample_o}, 32'h0);
    wr(ltpc_pkg::IDX_RSVD_CFG, 32'hFF);
    rd_chk(ltpc_pkg::IDX_RSVD_CFG, 32'h01);
    apb(1'b0, 12'h0FC, 32'h0);
    check_val({31'h0, rerr}, 32'h1);
    apb(1'b1, 12'h29A, 32'h0);
    check_val({31'h0, rerr}, 32'h1);
    // interrupt: raise, clear, mask
    wr(ltpc_pkg::IDX_IRQ_ENABLE, 32'h1);
    rd_chk(ltpc_pkg::IDX_IRQ_ENABLE, 32'h1);
    wr(ltpc_pkg::IDX_SRC_PERS, 32'h01);
    send(16'h012C, 16'h0000, 1'b1);
    check_val({31'h0, irq_o}, 32'h1);
    rd_chk(ltpc_pkg::IDX_IRQ_STATUS, 32'h3);
    wr(ltpc_pkg::IDX_IRQ_CLEAR, 32'h3);
    @(posedge clk_i);
    #1;
    check_val({31'h0, irq_o}, 32'h0);
    rd_chk(ltpc_pkg::IDX_IRQ_STATUS, 32'h0);
    wr(ltpc_pkg::IDX_IRQ_ENABLE, 32'h0);
    send(16'h012C, 16'h0000, 1'b1);
    check_val({31'h0, irq_o}, 32'h0);
    rd_chk(ltpc_pkg::IDX_IRQ_STATUS, 32'h3);
    wr(ltpc_pkg::IDX_IRQ_CLEAR, 32'h3);
    // range boundaries are inside
    send(16'h0064, 16'h0000, 1'b0);
    send(16'h00C8, 16'h0000, 1'b0);
    send(16'h0063, 16'h0000, 1'b1);
    send(16'h00C9, 16'h0000, 1'b1);
    // source select picks modulator one
    wr(ltpc_pkg::IDX_SRC_PERS, 32'h11);
    @(posedge clk_i);
    #1;
    check_val({30'h0, compare_source_select_o}, 32'h1);
    send(16'h012C, 16'h0096, 1'b0);
    send(16'h0096, 16'h012C, 1'b1);
    wr(ltpc_pkg::IDX_SRC_PERS, 32'h21);
    send(16'h012C, 16'h0096, 1'b1);
    // in-range sample restarts the count
    wr(ltpc_pkg::IDX_SRC_PERS, 32'h03);
    send(16'h012C, 16'h0000, 1'b0);
    send(16'h012C, 16'h0000, 1'b0);
    send(16'h0096, 16'h0000, 1'b0);
    send(16'h012C, 16'h0000, 1'b0);
    send(16'h012C, 16'h0000, 1'b0);
    send(16'h012C, 16'h0000, 1'b1);
    // every persistence code
    wr(ltpc_pkg::IDX_SRC_PERS, 32'h00);
    send(16'h0096, 16'h0000, 1'b1);
    send(16'h0096, 16'h0000, 1'b1);
    for (int p = 1; p < 16; p++) begin
      tgt = (p < 4) ? p : 5 * (p - 3);
      wr(ltpc_pkg::IDX_SRC_PERS, p);
      for (int k = 1; k < tgt; k++) send(16'h012C, 16'h0000, 1'b0);
      send(16'h012C, 16'h0000, 1'b1);
    end
    // residual floor and ceiling
    for (int f = 0; f < 4; f++) begin
      for (int c = 0; c < 4; c++) begin
        wr(ltpc_pkg::IDX_STARTUP_RESID, (f << 2) | c);
        for (int r = 0; r < 8; r++) begin
          @(posedge clk_i);
          residual_req_i <= r[2:0];
          repeat (2) @(posedge clk_i);
          #1;
          check_val({29'h0, residual_bits_o}, (r < f ? f : r) > c + 1 ? c + 1 : (r < f ? f : r));
        end
      end
    end
    // full startup per sample
    wr(ltpc_pkg::IDX_STARTUP_RESID, 32'h20);
    rd_chk(ltpc_pkg::IDX_STARTUP_RESID, 32'h20);
    check_val({31'h0, full_startup_per_sample_o}, 32'h1);
    print_verdict();
  end
endmodule

`default_nettype wire
